// >>> design/dpsfe_pkg.sv
// Purpose: Shared constants and types of the dual pot serial front end.
// Assumes: System clock of 50 ns; instruction byte first after select.
// Notes:   Instruction layout is opcode[7:4], pot[3], stored index[2:1], dir[0].
package dpsfe_pkg;

  localparam int NUM_POTS       = 2;
  localparam int STORED_PER_POT = 4;
  localparam int NUM_STORED     = NUM_POTS * STORED_PER_POT;
  localparam int WIPER_W        = 6;
  localparam int NUM_TAPS       = 64;
  localparam int BYTE_W         = 8;
  localparam int WORD_W         = 16;

  // Opcode field and its six accepted values
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int POT_BIT = 3;
  localparam int IDX_MSB = 2;
  localparam int IDX_LSB = 1;
  localparam int DIR_BIT = 0;

  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'ha;
  localparam logic [3:0] OP_RD_STORED = 4'hb;
  localparam logic [3:0] OP_WR_STORED = 4'hc;
  localparam logic [3:0] OP_TRANSFER  = 4'hd;
  localparam logic [3:0] OP_INCDEC    = 4'h2;

  // Byte phases of a sequence
  localparam logic [1:0] PH_OPCODE = 2'h0;
  localparam logic [1:0] PH_DATA   = 2'h1;
  localparam logic [1:0] PH_DONE   = 2'h2;
  localparam logic [1:0] PH_REJECT = 2'h3;

  localparam logic [5:0] STORED_RESET = 6'h00;
  localparam logic [5:0] WIPER_MAX    = 6'h3f;

  localparam int CLK_PERIOD_NS = 50;
  localparam int NV_WRITE_NS   = 100000;
  localparam logic [15:0] NV_WRITE_CYC =
    16'((NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SCK_HALF_CYC = 8;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_LOW,
    HS_HIGH,
    HS_TAIL,
    HS_GAP
  } dpsfe_host_state_t;

endpackage

// >>> design/dpsfe_link_if.sv
// Purpose: Serial link between the host controller and the pot front end.
// Assumes: Serial output line idles high when nobody drives it.
// Notes:   Output enable high while the device drives the line.
`timescale 1ns/1ps
interface dpsfe_link_if;
  logic csN;
  logic sck;
  logic si;
  logic holdN;
  logic wpN;
  logic soOut;
  logic soOe;
  logic soLine;

  // Pull-up stands in for the floating line
  assign soLine = soOe ? soOut : 1'b1;

  modport device (
    input  csN,
    input  sck,
    input  si,
    input  holdN,
    input  wpN,
    output soOut,
    output soOe
  );

  modport host (
    output csN,
    output sck,
    output si,
    output holdN,
    output wpN,
    input  soLine
  );
endinterface

// >>> design/dpsfe_device.sv
// Purpose: Device end: serial front end with wiper and stored setting registers.
// Assumes: All link pins are asynchronous and pass two flip-flops first.
// Notes:   Stored settings are flip-flops; reset stands in for power-up recall.
`timescale 1ns/1ps
module dpsfe_device (
  input  wire logic                                     clk_sys,
  input  wire logic                                     rst_n,
  input  wire logic                                     ce,
  dpsfe_link_if.device                                  link,
  output logic [dpsfe_pkg::NUM_POTS-1:0][dpsfe_pkg::WIPER_W-1:0]  wiperCode,
  output logic [dpsfe_pkg::NUM_POTS-1:0][dpsfe_pkg::NUM_TAPS-1:0] tapSel,
  output logic                                          nvBusy
);
  import dpsfe_pkg::*;

  typedef struct packed {
    logic [1:0]                           sckSy;
    logic [1:0]                           csSy;
    logic [1:0]                           siSy;
    logic [1:0]                           holdSy;
    logic [1:0]                           wpSy;
    logic                                 sckPrev;
    logic                                 paused;
    logic                                 drive;
    logic [3:0]                           bitCnt;
    logic [1:0]                           phase;
    logic [BYTE_W-1:0]                    shIn;
    logic [BYTE_W-1:0]                    instr;
    logic [BYTE_W-1:0]                    shOut;
    logic                                 soOut;
    logic                                 soOe;
    logic [NUM_POTS-1:0][WIPER_W-1:0]     wiper;
    logic [NUM_STORED-1:0][WIPER_W-1:0]   stored;
    logic                                 pendNv;
    logic [2:0]                           nvAddr;
    logic [WIPER_W-1:0]                   nvData;
    logic [15:0]                          busyCnt;
    logic                                 nvBusy;
    logic [NUM_POTS-1:0][NUM_TAPS-1:0]    tap;
  } dpsfe_dev_state_t;

  dpsfe_dev_state_t r;
  dpsfe_dev_state_t n;

  function automatic logic [NUM_TAPS-1:0] tapDecode(input logic [WIPER_W-1:0] code);
    tapDecode = {{(NUM_TAPS-1){1'b0}}, 1'b1} << code;
  endfunction

  function automatic logic opValid(input logic [3:0] op);
    opValid = (op == OP_RD_WIPER) || (op == OP_WR_WIPER) || (op == OP_RD_STORED)
           || (op == OP_WR_STORED) || (op == OP_TRANSFER) || (op == OP_INCDEC);
  endfunction

  logic                sckS;
  logic                csS;
  logic                siS;
  logic                holdS;
  logic                wpS;
  logic                rise;
  logic                fall;
  logic                busy;
  logic [BYTE_W-1:0]   inByte;
  logic [3:0]          op;
  logic                pot;
  logic [2:0]          sIdx;

  always_comb begin
    n = r;
    n.sckSy  = {r.sckSy[0], link.sck};
    n.csSy   = {r.csSy[0], link.csN};
    n.siSy   = {r.siSy[0], link.si};
    n.holdSy = {r.holdSy[0], link.holdN};
    n.wpSy   = {r.wpSy[0], link.wpN};
    sckS  = r.sckSy[1];
    csS   = r.csSy[1];
    siS   = r.siSy[1];
    holdS = r.holdSy[1];
    wpS   = r.wpSy[1];
    rise  = sckS & ~r.sckPrev;
    fall  = ~sckS & r.sckPrev;
    n.sckPrev = sckS;
    inByte = {r.shIn[BYTE_W-2:0], siS};
    op    = r.instr[OPC_MSB:OPC_LSB];
    pot   = r.instr[POT_BIT];
    sIdx  = {r.instr[POT_BIT], r.instr[IDX_MSB:IDX_LSB]};
    busy  = r.busyCnt != 16'h0000;
    if (busy) begin
      n.busyCnt = r.busyCnt - 16'h0001;
    end
    if (csS || busy) begin
      // Deselected, or held off by a running stored write
      n.drive  = 1'b0;
      n.paused = 1'b0;
      n.bitCnt = 4'h0;
      n.phase  = PH_OPCODE;
      if (csS && r.pendNv && wpS && !busy) begin
        n.stored[r.nvAddr] = r.nvData;
        n.busyCnt          = NV_WRITE_CYC;
      end
      if (csS) begin
        n.pendNv = 1'b0;
      end
    end else begin
      if (!wpS) begin
        n.pendNv = 1'b0;
      end
      if (!sckS) begin
        n.paused = ~holdS;
      end
      if (r.paused || (!sckS && !holdS)) begin
        // Edges and input changes ignored; position held
        n.paused = n.paused;
      end else if (rise) begin
        n.shIn   = inByte;
        n.bitCnt = r.bitCnt + 4'h1;
        if (r.phase == PH_OPCODE && r.bitCnt == 4'h7) begin
          n.instr  = inByte;
          n.bitCnt = 4'h0;
          n.phase  = opValid(inByte[OPC_MSB:OPC_LSB]) ? PH_DATA : PH_REJECT;
          unique case (inByte[OPC_MSB:OPC_LSB])
            OP_RD_WIPER:  n.shOut = {2'b00, r.wiper[inByte[POT_BIT]]};
            OP_RD_STORED: n.shOut = {2'b00,
                            r.stored[{inByte[POT_BIT], inByte[IDX_MSB:IDX_LSB]}]};
            OP_TRANSFER: begin
              n.phase = PH_DONE;
              if (inByte[DIR_BIT]) begin
                n.pendNv = wpS;
                n.nvAddr = {inByte[POT_BIT], inByte[IDX_MSB:IDX_LSB]};
                n.nvData = r.wiper[inByte[POT_BIT]];
              end else begin
                n.wiper[inByte[POT_BIT]] =
                  r.stored[{inByte[POT_BIT], inByte[IDX_MSB:IDX_LSB]}];
              end
            end
            default: n.shOut = r.shOut;
          endcase
        end else if (r.phase == PH_DATA && op == OP_INCDEC) begin
          // One bit per step: high raises, low lowers, both saturate
          if (siS && r.wiper[pot] != WIPER_MAX) begin
            n.wiper[pot] = r.wiper[pot] + 6'h01;
          end else if (!siS && r.wiper[pot] != 6'h00) begin
            n.wiper[pot] = r.wiper[pot] - 6'h01;
          end
        end else if (r.phase == PH_DATA && r.bitCnt == 4'h7) begin
          n.phase = PH_DONE;
          if (op == OP_WR_WIPER) begin
            n.wiper[pot] = inByte[WIPER_W-1:0];
          end else if (op == OP_WR_STORED) begin
            n.pendNv = wpS;
            n.nvAddr = sIdx;
            n.nvData = inByte[WIPER_W-1:0];
          end
        end
      end else if (fall) begin
        if (r.phase != PH_OPCODE && r.phase != PH_REJECT
            && (op == OP_RD_WIPER || op == OP_RD_STORED)) begin
          n.soOut = r.shOut[BYTE_W-1];
          n.shOut = {r.shOut[BYTE_W-2:0], 1'b0};
          n.drive = 1'b1;
        end
      end
    end
    n.soOe   = n.drive && !n.paused;
    n.nvBusy = n.busyCnt != 16'h0000;
    for (int p = 0; p < NUM_POTS; p++) begin
      n.tap[p] = tapDecode(n.wiper[p]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.csSy   <= 2'b11;
      r.holdSy <= 2'b11;
      r.wpSy   <= 2'b11;
      r.wiper  <= {NUM_POTS{STORED_RESET}};
      r.stored <= {NUM_STORED{STORED_RESET}};
      r.tap    <= {NUM_POTS{tapDecode(STORED_RESET)}};
    end else if (ce) begin
      r <= n;
    end
  end

  assign link.soOut = r.soOut;
  assign link.soOe  = r.soOe;
  assign wiperCode  = r.wiper;
  assign tapSel     = r.tap;
  assign nvBusy     = r.nvBusy;

endmodule

// >>> design/dpsfe_host.sv
// Purpose: Host end: serial master making select, clock, data, pause, inhibit.
// Assumes: Serial clock made here by dividing the system clock.
// Notes:   Command word is sent left-aligned, most significant bit first.
`timescale 1ns/1ps
module dpsfe_host #(
  parameter int HALF_CYC = dpsfe_pkg::SCK_HALF_CYC
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic                           ce,
  dpsfe_link_if.host                          link,
  input  wire logic                           cmdValid,
  input  wire logic [4:0]                     cmdBits,
  input  wire logic [dpsfe_pkg::WORD_W-1:0]   cmdWord,
  input  wire logic                           pauseReq,
  input  wire logic                           wpLevel,
  output logic                                cmdReady,
  output logic [dpsfe_pkg::BYTE_W-1:0]        rdData,
  output logic                                rdValid
);
  import dpsfe_pkg::*;

  typedef struct packed {
    dpsfe_host_state_t     st;
    logic [7:0]            div;
    logic [4:0]            bitsLeft;
    logic [WORD_W-1:0]     tx;
    logic [BYTE_W-1:0]     rx;
    logic [1:0]            soSy;
    logic                  csN;
    logic                  sck;
    logic                  si;
    logic                  holdN;
    logic                  wpN;
    logic                  ready;
    logic [BYTE_W-1:0]     rdData;
    logic                  rdValid;
  } dpsfe_host_reg_t;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  dpsfe_host_reg_t r;
  dpsfe_host_reg_t n;
  logic            divDone;

  always_comb begin
    n         = r;
    n.soSy    = {r.soSy[0], link.soLine};
    n.wpN     = wpLevel;
    n.rdValid = 1'b0;
    divDone   = r.div == HALF_LAST;
    n.div     = divDone ? 8'h00 : r.div + 8'h01;
    unique case (r.st)
      HS_IDLE: begin
        n.ready = 1'b1;
        n.div   = 8'h00;
        if (cmdValid && cmdBits != 5'h00) begin
          n.ready    = 1'b0;
          n.csN      = 1'b0;
          n.tx       = cmdWord;
          n.si       = cmdWord[WORD_W-1];
          n.bitsLeft = cmdBits;
          n.st       = HS_LOW;
        end
      end
      HS_LOW: begin
        if (pauseReq || !r.holdN) begin
          // Pause and resume only with the clock low
          n.holdN = ~pauseReq;
          n.div   = 8'h00;
        end else if (divDone) begin
          n.sck = 1'b1;
          n.st  = HS_HIGH;
        end
      end
      HS_HIGH: begin
        if (divDone) begin
          n.rx       = {r.rx[BYTE_W-2:0], r.soSy[1]};
          n.tx       = {r.tx[WORD_W-2:0], 1'b0};
          n.bitsLeft = r.bitsLeft - 5'h01;
          n.sck      = 1'b0;
          n.si       = r.tx[WORD_W-2];
          n.st       = (r.bitsLeft == 5'h01) ? HS_TAIL : HS_LOW;
        end
      end
      HS_TAIL: begin
        if (divDone) begin
          n.csN     = 1'b1;
          n.rdData  = r.rx;
          n.rdValid = 1'b1;
          n.st      = HS_GAP;
        end
      end
      HS_GAP: begin
        if (divDone) begin
          n.st = HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r       <= '0;
      r.st    <= HS_IDLE;
      r.csN   <= 1'b1;
      r.holdN <= 1'b1;
      r.wpN   <= 1'b1;
      r.soSy  <= 2'b11;
    end else if (ce) begin
      r <= n;
    end
  end

  assign link.csN   = r.csN;
  assign link.sck   = r.sck;
  assign link.si    = r.si;
  assign link.holdN = r.holdN;
  assign link.wpN   = r.wpN;
  assign cmdReady   = r.ready;
  assign rdData     = r.rdData;
  assign rdValid    = r.rdValid;

endmodule

// >>> verification/dpsfe_monitor.sv
// Purpose: Wire checks on the pot serial link.
// Assumes: One system clock for both ends; host half period 8 clocks.
// Notes:   Device pin latency is under 6 clocks.
`timescale 1ns/1ps
module dpsfe_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic soOut,
  input wire logic soOe,
  input wire logic soLine
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  float_desel_a: assert property (csN [*6] |-> !soOe)
    else $error("output driven while deselected");
  // Device decides from pins seen three clocks earlier
  drive_start_a: assert property ($rose(soOe) |-> !$past(csN, 3) && $past(holdN, 3))
    else $error("output drive began outside a selected transfer");
  float_paused_a: assert property ((!holdN) [*6] |-> !soOe && soLine)
    else $error("output driven while paused");
  so_fall_a: assert property (soOe && $changed(soOut) |-> !sck)
    else $error("output changed in clock high phase");
  pause_low_a: assert property ($fell(holdN) |-> !sck)
    else $error("pause entered with clock high");
  resume_low_a: assert property ($rose(holdN) |-> !sck)
    else $error("pause left with clock high");
  clk_frozen_a: assert property (!holdN |-> $stable(sck))
    else $error("clock moved while paused");
  si_stable_a: assert property (sck && $past(sck) |-> $stable(si))
    else $error("data changed in clock high phase");
  hold_idle_a: assert property (csN |-> holdN)
    else $error("pause low while deselected");
  first_byte_a: assert property ($fell(csN) |-> (!sck) [*3])
    else $error("clock rose too soon after select");

  cover property ($fell(holdN));
  cover property ($rose(soOe));
  cover property (!wpN && $rose(csN));
endmodule

// >>> verification/dual_pot_serial_front_end_bench.sv
// Purpose: Host and device ends joined; user sides driven and judged.
// Assumes: Host half period of 8 clocks; stored write of NV_WRITE_CYC.
// Notes:   Instruction byte op, pot, index, dir; data byte low 6 bits.
`timescale 1ns/1ps
module dual_pot_serial_front_end_bench;
  import dpsfe_pkg::*;
  logic                              ceOn;
  logic                              clk_sys;
  logic                              rst_n;
  logic                              cmdValid;
  logic [4:0]                        cmdBits;
  logic [15:0]                       cmdWord;
  logic                              pauseReq;
  logic                              wpLevel;
  logic                              cmdReady;
  logic [7:0]                        rdData;
  logic                              rdValid;
  logic                              nvBusy;
  logic [NUM_POTS-1:0][WIPER_W-1:0]  wiperCode;
  logic [NUM_POTS-1:0][NUM_TAPS-1:0] tapSel;
  int                                err_total;
  int                                n_checks;

  dpsfe_link_if link ();
  dpsfe_device i_dpsfe_device (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ceOn), .link(link),
    .wiperCode(wiperCode), .tapSel(tapSel), .nvBusy(nvBusy));
  dpsfe_host #(.HALF_CYC(8)) i_dpsfe_host (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ceOn),
    .link(link), .cmdValid(cmdValid), .cmdBits(cmdBits), .cmdWord(cmdWord),
    .pauseReq(pauseReq), .wpLevel(wpLevel), .cmdReady(cmdReady), .rdData(rdData),
    .rdValid(rdValid));
  dpsfe_monitor i_dpsfe_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .csN(link.csN),
    .sck(link.sck), .si(link.si), .holdN(link.holdN), .wpN(link.wpN),
    .soOut(link.soOut), .soOe(link.soOe), .soLine(link.soLine));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One command through the host, then settle the device
  task automatic send(input logic [15:0] w, input logic [4:0] n);
    int k;
    k = 0;
    while (cmdReady !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    cmdWord = w;
    cmdBits = n;
    cmdValid = 1'b1;
    tick(1);
    cmdValid = 1'b0;
    k = 0;
    while (rdValid !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    chk(rdValid, 1'b1);
    tick(8);
  endtask

  task automatic wiper_of(input int p, input logic [5:0] v);
    chk(wiperCode[p], v);
    chk(tapSel[p], 64'h1 << v);
  endtask

  task automatic nv_wait();
    int k;
    chk(nvBusy, 1'b1);
    k = 0;
    while (nvBusy === 1'b1 && k < 2200) begin
      tick(1);
      k++;
    end
    chk(nvBusy, 1'b0);
  endtask

  task automatic t_wiper();
    send(16'ha015, 5'd16);
    wiper_of(0, 6'h15);
    wiper_of(1, 6'h00);
    send(16'h9000, 5'd16);
    chk(rdData, 8'h15);
  endtask

  task automatic t_incdec();
    send(16'h20c0, 5'd11);
    wiper_of(0, 6'h16);
    send(16'h2880, 5'd9);
    wiper_of(1, 6'h01);
    wiper_of(0, 6'h16);
    send(16'h2800, 5'd10);
    wiper_of(1, 6'h00);
  endtask

  task automatic t_stored();
    send(16'hc22a, 5'd16);
    nv_wait();
    wiper_of(0, 6'h16);
    send(16'hb200, 5'd16);
    chk(rdData, 8'h2a);
    send(16'hd200, 5'd8);
    wiper_of(0, 6'h2a);
    send(16'ha00c, 5'd16);
    send(16'hd500, 5'd8);
    nv_wait();
    send(16'hb400, 5'd16);
    chk(rdData, 8'h0c);
  endtask

  // Write inhibit blocks stored writes but not wiper writes; opcode one bit away from write wiper must do nothing
  task automatic t_inhibit();
    wpLevel = 1'b0;
    send(16'hc211, 5'd16);
    chk(nvBusy, 1'b0);
    send(16'ha011, 5'd16);
    wiper_of(0, 6'h11);
    wpLevel = 1'b1;
    send(16'hb200, 5'd16);
    chk(rdData, 8'h2a);
    send(16'he033, 5'd16);
    wiper_of(0, 6'h11);
  endtask

  // Pause in the middle of the read data byte
  task automatic t_pause();
    fork
      send(16'h9000, 5'd16);
      begin
        tick(200);
        pauseReq = 1'b1;
        tick(40);
        chk(link.holdN, 1'b0);
        chk(link.soOe, 1'b0);
        pauseReq = 1'b0;
      end
    join
    chk(rdData, 8'h11);
  endtask

  // Both ends frozen in mid read; the transfer then resumes intact
  task automatic t_freeze();
    logic sckHeld;
    fork
      send(16'hb200, 5'd16);
      begin
        tick(150);
        ceOn = 1'b0;
        sckHeld = link.sck;
        tick(30);
        chk(link.sck, sckHeld);
        chk(link.csN, 1'b0);
        ceOn = 1'b1;
      end
    join
    chk(rdData, 8'h2a);
  endtask

  // Second reset in mid-run: wipers and stored settings back to zero
  task automatic t_reset();
    rst_n = 1'b0;
    tick(4);
    rst_n = 1'b1;
    tick(2);
    wiper_of(0, 6'h00);
    chk(link.soOe, 1'b0);
    send(16'hb200, 5'd16);
    chk(rdData, 8'h00);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    err_total++;
    end_of_test();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdBits = 5'h00;
    cmdWord = 16'h0000;
    pauseReq = 1'b0;
    wpLevel = 1'b1;
    ceOn = 1'b1;
    tick(4);
    rst_n = 1'b1;
    tick(2);
    wiper_of(0, 6'h00);
    t_wiper();
    t_incdec();
    t_stored();
    t_inhibit();
    t_pause();
    t_freeze();
    t_reset();
    end_of_test();
  end
endmodule
